/* rtl/bic_pkg.sv */
// Package for the bus idle cycle inserter: offsets, field layout, types.
package bic_pkg;

	// ********************************************************
	// Register map
	// ********************************************************
	localparam logic [11:0] BIC_SBC_OFFSET = 12'h000; // Space bus control word
	localparam int          BIC_ADDR_W     = 12;      // Decoded address width

	// ********************************************************
	// Field layout of the space bus control word
	// ********************************************************
	localparam int         BIC_FIELD_W  = 3;    // Every idle-count field is 3 bits
	localparam int         BIC_RWD_LSB  = 25;   // Read-write, other space
	localparam int         BIC_RWS_LSB  = 22;   // Read-write, same space
	localparam int         BIC_RRD_LSB  = 19;   // Read-read, other space
	localparam logic [2:0] BIC_IDLE_RST = 3'h3; // Value after reset of each field

	// ********************************************************
	// Timing
	// ********************************************************
	localparam int         BIC_CNT_W    = 4;    // Idle and access counter width
	localparam logic [3:0] BIC_ACC_CYC  = 4'h2; // Strobe-active cycles per access

	// ********************************************************
	// Types
	// ********************************************************
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00, // Waiting for a request
		ST_ACCESS = 2'b01, // Strobes active
		ST_GAP    = 2'b10  // Inserted idle cycles
	} bic_state_t;

	typedef struct packed {
		logic        sel;    // Slave selected
		logic        enable; // Access phase
		logic        write;  // Direction
		logic [11:0] addr;   // Byte address
		logic [31:0] wdata;  // Write data
	} bic_apb_req_t;

	typedef struct packed {
		logic valid; // Request pending
		logic write; // Write access
		logic own;   // Targets this space
	} bic_acc_req_t;

	typedef struct packed {
		logic [2:0] rd_wr_other; // idle_rd_wr_other_space
		logic [2:0] rd_wr_same;  // idle_rd_wr_same_space
		logic [2:0] rd_rd_other; // idle_rd_rd_other_space
	} bic_fields_t;

endpackage : bic_pkg

/* rtl/bic_idle_decode.sv */
// Decoder from a 3-bit idle-count code to a number of idle cycles.
module bic_idle_decode
	import bic_pkg::*;
(
	input  logic [2:0] code_i,   // Idle-count code
	output logic [3:0] cycles_o  // Idle cycles to insert
);

	// ********************************************************
	// Code table; steps grow by two above code 2
	// ********************************************************
	always_comb begin
		case (code_i)
			3'h0:    cycles_o = 4'h0;
			3'h1:    cycles_o = 4'h1;
			3'h2:    cycles_o = 4'h2;
			3'h3:    cycles_o = 4'h4;
			3'h4:    cycles_o = 4'h6;
			3'h5:    cycles_o = 4'h8;
			3'h6:    cycles_o = 4'hA;
			3'h7:    cycles_o = 4'hC;
			default: cycles_o = 4'h0;
		endcase
	end

endmodule : bic_idle_decode

/* rtl/bic_down_timer.sv */
// Loadable down counter that flags the last cycle of a loaded span.
module bic_down_timer #(
	parameter int W = 4 // Counter width
) (
	input  logic         clk_i,    // Bus clock
	input  logic         rst_n_i,  // Synchronous reset, active low
	input  logic         load_i,   // Load a new span
	input  logic [W-1:0] value_i,  // Span length in cycles
	output logic         expire_o  // Last cycle of the span
);

	logic [W-1:0] count;      // Remaining cycles
	logic [W-1:0] next_count; // Next remaining cycles

	// ********************************************************
	// Next count
	// ********************************************************
	always_comb begin
		next_count = count;
		if (load_i) begin
			next_count = value_i;
		end else if (count != '0) begin
			next_count = count - 1'b1;
		end
	end

	// Register only
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	// A span of N cycles expires on its Nth cycle
	assign expire_o = (count == {{(W-1){1'b0}}, 1'b1});

endmodule : bic_down_timer

/* rtl/bic_top.sv */
// Bus idle cycle inserter: control word on APB and access sequencer.
//
// Overview of operation
// - Read then write same space: field 24:22.
// - Read then read other space: field 21:19.
// - Codes map to 0,1,2,4,6,8,10,12 cycles.
// - Idles follow access end; fields read/write.
// - Bit 25 is field LSB, resets one.
// - Field 27:25 for read then write elsewhere.
module bic_top
	import bic_pkg::*;
#(
	parameter logic [3:0] ACC_CYCLES = BIC_ACC_CYC // Strobe cycles per access
) (
	input  logic                           MCLK_I,      // Bus clock, 25 MHz
	input  logic                           RST_N_I,     // Synchronous reset, active low
	input  logic                           PSEL_I,      // APB select
	input  logic                           PENABLE_I,   // APB access phase
	input  logic                           PWRITE_I,    // APB direction
	input  logic [bic_pkg::BIC_ADDR_W-1:0] PADDR_I,     // APB byte address
	input  logic [31:0]                    PWDATA_I,    // APB write data
	output logic [31:0]                    PRDATA_O,    // APB read data
	output logic                           PREADY_O,    // APB ready
	output logic                           PSLVERR_O,   // APB error, unmapped address
	input  logic                           REQ_VALID_I, // Access request pending
	input  logic                           REQ_WRITE_I, // Request is a write
	input  logic                           REQ_OWN_I,   // Request targets this space
	output logic                           REQ_READY_O, // Request taken this cycle
	output logic                           CS_N_O,      // Chip select of this space
	output logic                           RD_N_O,      // Read strobe
	output logic                           WR_N_O,      // Write strobe
	output logic                           IDLE_GAP_O   // Inserted idle cycles running
);
	import bic_pkg::*;

	// ********************************************************
	// Declarations
	// ********************************************************
	bic_apb_req_t apb;            // Bundled APB request
	bic_acc_req_t acc;            // Bundled access request
	bic_fields_t  fields;         // Stored idle-count fields
	bic_fields_t  next_fields;    // Next idle-count fields
	logic [31:0]  next_prdata;    // Next read data
	logic         hit;            // Address hits the control word
	logic [31:0]  word;           // Assembled control word
	bic_state_t   state;          // Sequencer state
	bic_state_t   next_state;     // Next sequencer state
	logic         last_rd;        // Last access was a read of this space and its idles are not yet inserted
	logic         next_last_rd;   // Next value of last_rd
	logic         cur_write;      // Direction of running access
	logic         next_cur_write; // Next direction
	logic         cur_own;        // Running access targets this space
	logic         next_cur_own;   // Next target
	logic         next_cs_n;      // Next chip select
	logic         next_rd_n;      // Next read strobe
	logic         next_wr_n;      // Next write strobe
	logic [2:0]   gap_code;       // Field chosen for the pending pair
	logic [3:0]   gap_cycles;     // Decoded idle cycles
	logic         need_gap;       // Idle cycles owed before the request
	logic         tmr_load;       // Start a span
	logic [3:0]   tmr_value;      // Span length
	logic         tmr_expire;     // Span on its last cycle

	assign apb = '{sel: PSEL_I, enable: PENABLE_I, write: PWRITE_I,
		addr: PADDR_I, wdata: PWDATA_I};
	assign acc = '{valid: REQ_VALID_I, write: REQ_WRITE_I, own: REQ_OWN_I};

	// ********************************************************
	// APB slave
	// ********************************************************

	// Zero-wait slave; only one word is mapped
	assign hit       = (apb.addr == BIC_SBC_OFFSET);
	assign PREADY_O  = 1'b1;
	assign PSLVERR_O = apb.sel && apb.enable && !hit;

	// Unimplemented and reserved bits read as zero
	always_comb begin
		word = 32'h0000_0000;
		word[BIC_RWD_LSB +: BIC_FIELD_W] = fields.rd_wr_other;
		word[BIC_RWS_LSB +: BIC_FIELD_W] = fields.rd_wr_same;
		word[BIC_RRD_LSB +: BIC_FIELD_W] = fields.rd_rd_other;
	end

	// Write lands in the access phase; read data is loaded in setup
	always_comb begin
		next_fields = fields;
		next_prdata = PRDATA_O;
		if (apb.sel && apb.enable && apb.write && hit) begin
			next_fields.rd_wr_other = apb.wdata[BIC_RWD_LSB +: BIC_FIELD_W];
			next_fields.rd_wr_same  = apb.wdata[BIC_RWS_LSB +: BIC_FIELD_W];
			next_fields.rd_rd_other = apb.wdata[BIC_RRD_LSB +: BIC_FIELD_W];
		end
		if (apb.sel && !apb.enable && !apb.write) begin
			// Unmapped reads return zero
			next_prdata = hit ? word : 32'h0000_0000;
		end
	end

	// Register only; every field comes up as code 3
	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			fields   <= '{BIC_IDLE_RST, BIC_IDLE_RST, BIC_IDLE_RST};
			PRDATA_O <= 32'h0000_0000;
		end else begin
			fields   <= next_fields;
			PRDATA_O <= next_prdata;
		end
	end

	// ********************************************************
	// Idle selection
	// ********************************************************

	// Only a read of this space owes idles; same-space read-read is
	// handled by a field outside this block, so it owes none here
	always_comb begin
		gap_code = 3'h0;
		if (last_rd && acc.valid) begin
			if (acc.own && acc.write) begin
				gap_code = fields.rd_wr_same;
			end else if (!acc.own && acc.write) begin
				gap_code = fields.rd_wr_other;
			end else if (!acc.own) begin
				gap_code = fields.rd_rd_other;
			end
		end
	end

	bic_idle_decode u_decode (
		.code_i   (gap_code),
		.cycles_o (gap_cycles)
	);

	assign need_gap = (gap_cycles != 4'h0);

	// Request is only taken once no idles are owed
	assign REQ_READY_O = (state == ST_IDLE) && !need_gap;
	assign IDLE_GAP_O  = (state == ST_GAP);

	// ********************************************************
	// Span timer shared by accesses and idle gaps
	// ********************************************************
	bic_down_timer #(
		.W (BIC_CNT_W)
	) u_timer (
		.clk_i    (MCLK_I),
		.rst_n_i  (RST_N_I),
		.load_i   (tmr_load),
		.value_i  (tmr_value),
		.expire_o (tmr_expire)
	);

	// ********************************************************
	// Access sequencer
	// ********************************************************

	// Next state, strobes and access history
	always_comb begin
		next_state     = state;
		next_last_rd   = last_rd;
		next_cur_write = cur_write;
		next_cur_own   = cur_own;
		next_cs_n      = CS_N_O;
		next_rd_n      = RD_N_O;
		next_wr_n      = WR_N_O;
		tmr_load       = 1'b0;
		tmr_value      = ACC_CYCLES;
		case (state)
			ST_IDLE: begin
				if (acc.valid && need_gap) begin
					// Idles sit after the ended access, before the next
					next_state   = ST_GAP;
					tmr_load     = 1'b1;
					tmr_value    = gap_cycles;
					next_last_rd = 1'b0;
				end else if (acc.valid) begin
					next_state     = ST_ACCESS;
					tmr_load       = 1'b1;
					next_cur_write = acc.write;
					next_cur_own   = acc.own;
					next_cs_n      = !acc.own;
					next_rd_n      = acc.write;
					next_wr_n      = !acc.write;
				end
			end
			ST_ACCESS: begin
				if (tmr_expire) begin
					next_state   = ST_IDLE;
					next_last_rd = cur_own && !cur_write;
					next_cs_n    = 1'b1;
					next_rd_n    = 1'b1;
					next_wr_n    = 1'b1;
				end
			end
			ST_GAP: begin
				// Strobes stay high for the whole gap
				if (tmr_expire) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
				next_cs_n  = 1'b1;
				next_rd_n  = 1'b1;
				next_wr_n  = 1'b1;
			end
		endcase
	end

	// Register only
	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			state     <= ST_IDLE;
			last_rd   <= 1'b0;
			cur_write <= 1'b0;
			cur_own   <= 1'b0;
			CS_N_O    <= 1'b1;
			RD_N_O    <= 1'b1;
			WR_N_O    <= 1'b1;
		end else begin
			state     <= next_state;
			last_rd   <= next_last_rd;
			cur_write <= next_cur_write;
			cur_own   <= next_cur_own;
			CS_N_O    <= next_cs_n;
			RD_N_O    <= next_rd_n;
			WR_N_O    <= next_wr_n;
		end
	end

	// ********************************************************
	// Assertions
	// ********************************************************
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (!RST_N_I);

	// Gap of four idles opening from the idle state
	sequence s_gap4_open;
		(state == ST_IDLE) && acc.valid && (gap_cycles == 4'h4);
	endsequence

	sequence s_gap4_run;
		(state == ST_GAP)[*4] ##1 (state == ST_IDLE);
	endsequence

	a_reset_fields: assert property (@(posedge MCLK_I) disable iff (1'b0)
		!RST_N_I |=> (word[27:19] == 9'h0DB))
		else $error("fields not at code 3 after reset");

	a_decode_ends: assert property (
		((gap_code == 3'h3) |-> (gap_cycles == 4'h4)) and
		((gap_code == 3'h7) |-> (gap_cycles == 4'hC)))
		else $error("idle code decoded wrongly");

	a_same_rdwr: assert property (
		last_rd && acc.valid && acc.own && acc.write |-> gap_code == word[24:22])
		else $error("same-space read-write field not chosen");

	a_other_rdrd: assert property (
		last_rd && acc.valid && !acc.own && !acc.write |-> gap_code == word[21:19])
		else $error("other-space read-read field not chosen");

	a_other_rdwr: assert property (
		last_rd && acc.valid && !acc.own && acc.write |-> gap_code == word[27:25])
		else $error("other-space read-write field not chosen");

	a_gap_length: assert property (s_gap4_open |=> s_gap4_run)
		else $error("four-cycle gap not held exactly");

	a_gap_quiet: assert property (
		(state == ST_GAP) |-> CS_N_O && RD_N_O && WR_N_O && !REQ_READY_O)
		else $error("bus active during idle gap");

	a_field_write: assert property (
		apb.sel && apb.enable && apb.write && hit |=>
		word[27:19] == $past(PWDATA_I[27:19]))
		else $error("control word write lost");

	a_read_back: assert property (
		apb.sel && !apb.enable && !apb.write && hit |=> PRDATA_O == $past(word))
		else $error("control word read back wrong");

	// A read of this space then an own write with a nonzero field must
	// open a gap instead of starting the write at once
	a_gap_entry: assert property (
		(state == ST_IDLE) && last_rd && acc.valid && acc.own && acc.write &&
		(fields.rd_wr_same != 3'h0) |=> (state == ST_GAP) && CS_N_O && WR_N_O)
		else $error("same-space gap not opened");

	// Last strobe cycle of an access
	sequence s_acc_last;
		(state == ST_ACCESS) && tmr_expire;
	endsequence

	// Every strobe released and the sequencer back to idle
	sequence s_bus_free;
		(state == ST_IDLE) && CS_N_O && RD_N_O && WR_N_O;
	endsequence

	a_access_end: assert property (s_acc_last |=> s_bus_free)
		else $error("strobes held past the access");

	// Both strobes low at once would drive the memory both ways
	a_one_strobe: assert property (!(!RD_N_O && !WR_N_O))
		else $error("read and write strobes active together");

endmodule : bic_top

/* bench/bic_mem_model.sv */
// Far-side memory model: measures strobe spans and quiet gaps between them.
module bic_mem_model (
	input  wire logic clk_i,   // Bus clock
	input  wire logic cs_n_i,  // Chip select, active low
	input  wire logic rd_n_i,  // Read strobe, active low
	input  wire logic wr_n_i,  // Write strobe, active low
	output int        acc_len, // Strobe span of last access
	output int        gap_len, // Quiet span before last access
	output int        n_acc    // Accesses seen
);
	timeunit 1ns;
	timeprecision 1ns;
	int run   = 0; // Current strobe span
	int quiet = 0; // Current quiet span
	initial begin
		acc_len = 0;
		gap_len = 0;
		n_acc   = 0;
	end
	// A strobe only counts while selected; idle cycles must show as quiet
	always @(posedge clk_i) begin
		if (!cs_n_i && (!rd_n_i || !wr_n_i)) begin
			if (run == 0) gap_len = quiet;
			run++;
			quiet = 0;
		end else begin
			if (run > 0) begin
				acc_len = run;
				n_acc++;
			end
			run = 0;
			quiet++;
		end
	end
endmodule : bic_mem_model

/* bench/tb_top.sv */
// Testbench: control word over APB and idle spacing of accesses.
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	// ****************
	// Signals
	// ****************
	localparam logic [3:0] ACC = 4'h3; // Strobe cycles, off the default
	logic mclk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0;
	logic rv = 0, rw = 0, ro = 0; // Access request
	logic [bic_pkg::BIC_ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic pready, pslverr, rready, cs_n, rd_n, wr_n, gap;
	int acc_len, gap_len, n_acc; // Partner measurements
	int bad_count = 0, n_checks = 0;
	int dec [8] = '{0, 1, 2, 4, 6, 8, 10, 12}; // Code to idle cycles
	int lsb [3] = '{bic_pkg::BIC_RWD_LSB, bic_pkg::BIC_RWS_LSB, bic_pkg::BIC_RRD_LSB};
	logic ww [3] = '{1'b1, 1'b1, 1'b0}; // Second access is a write
	logic oo [3] = '{1'b0, 1'b1, 1'b0}; // Second access is own space
	always #20 mclk = ~mclk;
	bic_top #(.ACC_CYCLES(ACC)) bic_top_i (
		.MCLK_I(mclk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
		.PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .REQ_VALID_I(rv), .REQ_WRITE_I(rw),
		.REQ_OWN_I(ro), .REQ_READY_O(rready), .CS_N_O(cs_n), .RD_N_O(rd_n),
		.WR_N_O(wr_n), .IDLE_GAP_O(gap)
	);
	bic_mem_model bic_mem_model_i (
		.clk_i(mclk), .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
		.acc_len(acc_len), .gap_len(gap_len), .n_acc(n_acc)
	);
	// ****************
	// Tasks
	// ****************
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task complete_run;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run
	// One APB transfer; the request stands until pready is seen high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int k;
		@(posedge mclk);
		psel   <= 1'b1;
		pen    <= 1'b0;
		pwr    <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge mclk);
		pen <= 1'b1;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		chk("apb ready", 32'h1, 32'(pready));
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen  <= 1'b0;
	endtask : apb
	// One access request; counts inserted idle cycles until it is taken
	task acc(input logic w, input logic o, output int idles);
		int k;
		@(posedge mclk);
		rv <= 1'b1;
		rw <= w;
		ro <= o;
		idles = 0;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
			if (gap === 1'b1) idles++;
		end while (rready !== 1'b1 && k < 100);
		chk("request taken", 32'h1, 32'(rready));
		rv <= 1'b0;
	endtask : acc
	// Bus must stay quiet through every idle cycle
	always @(posedge mclk) begin
		if (gap === 1'b1) chk("strobes in gap", 32'h7, 32'({cs_n, rd_n, wr_n}));
	end
	// Hang guard, far beyond the expected run
	initial begin
		repeat (20000) @(posedge mclk);
		bad_count++;
		complete_run();
	end
	// ****************
	// Main sequence
	// ****************
	initial begin
		logic [31:0] rd, word;
		logic        err;
		int          idl, na;
		void'($urandom(78));
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		apb(1'b1, 12'h004, 32'hFFFFFFFF, rd, err);
		chk("unmapped write err", 32'h1, 32'(err));
		apb(1'b0, 12'h004, 32'h0, rd, err);
		chk("unmapped read", 32'h0, rd);
		apb(1'b0, 12'h000, 32'h0, rd, err);
		chk("reset word", 32'h06D80000, rd);
		apb(1'b1, 12'h000, 32'hFFFFFFFF, rd, err);
		apb(1'b0, 12'h000, 32'h0, rd, err);
		chk("all ones word", 32'h0FF80000, rd);
		// Every code of every field, with random codes in the others
		for (int f = 0; f < 3; f++) begin
			for (int c = 0; c < 8; c++) begin
				word = $urandom() & 32'h0FF80000;
				word[lsb[f] +: 3] = 3'(c);
				apb(1'b1, 12'h000, word, rd, err);
				apb(1'b0, 12'h000, 32'h0, rd, err);
				chk("word readback", word, rd);
				na = n_acc;
				acc(1'b0, 1'b1, idl);
				acc(ww[f], oo[f], idl);
				chk("idle count", 32'(dec[c]), 32'(idl));
				repeat (ACC + 3) @(posedge mclk);
				#1;
				chk("strobe span", 32'(ACC), 32'(acc_len));
				chk("own accesses", 32'(na + 1 + int'(oo[f])), 32'(n_acc));
				if (oo[f]) chk("quiet gap", 32'h1, 32'(gap_len > dec[c]));
			end
		end
		// Own read after own read uses none of these fields
		acc(1'b0, 1'b1, idl);
		acc(1'b0, 1'b1, idl);
		chk("read read idle", 32'h0, 32'(idl));
		complete_run();
	end
endmodule : tb_top
